// File: logic/fsc_pkg.sv
package fsc_pkg;
  // ----------------------------------------
  // Storage geometry
  // ----------------------------------------
  localparam logic [15:0] FSC_BLOCK_TOTAL    = 16'h0077;  // 119 blocks
  localparam logic [15:0] FSC_BLOCK_BYTES    = 16'h0200;  // 512 bytes per block

  // ----------------------------------------
  // Addressing of the storage service
  // ----------------------------------------
  localparam logic [15:0] FSC_CLUSTER        = 16'h0023;
  localparam logic [7:0]  FSC_ENDPOINT       = 8'hE6;

  // ----------------------------------------
  // Command codes and status
  // ----------------------------------------
  localparam logic [7:0]  FSC_CMD_GEOM_QUERY = 8'h00;
  localparam logic [7:0]  FSC_CMD_GEOM_REPLY = 8'h80;
  localparam logic [7:0]  FSC_REPLY_FLAG     = 8'h80;     // Reply code = request | flag
  localparam logic [7:0]  FSC_STATUS_OK      = 8'h00;
  localparam logic [7:0]  FSC_STATUS_ERR     = 8'h01;     // Bit 0 flags an error

  // ----------------------------------------
  // Header layout, byte positions
  // ----------------------------------------
  localparam int          FSC_HDR_LEN        = 8;
  localparam logic [3:0]  FSC_POS_CMD        = 4'h0;
  localparam logic [3:0]  FSC_POS_OPT        = 4'h1;
  localparam logic [3:0]  FSC_POS_BLK_HI     = 4'h2;
  localparam logic [3:0]  FSC_POS_BLK_LO     = 4'h3;
  localparam logic [3:0]  FSC_POS_OFS_HI     = 4'h4;
  localparam logic [3:0]  FSC_POS_OFS_LO     = 4'h5;
  localparam logic [3:0]  FSC_POS_CNT_HI     = 4'h6;
  localparam logic [3:0]  FSC_POS_CNT_LO     = 4'h7;
  localparam logic [3:0]  FSC_POS_LAST       = 4'h7;
  localparam logic [3:0]  FSC_POS_ZERO       = 4'h0;
  localparam logic [3:0]  FSC_POS_ONE        = 4'h1;

  // ----------------------------------------
  // Decoded header
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  opts;
    logic [15:0] blk;
    logic [15:0] ofs;
    logic [15:0] cnt;
  } fsc_hdr_t;

  // Byte at a header position, most significant first
  function automatic logic [7:0] fsc_hdr_byte(input fsc_hdr_t h, input logic [3:0] pos);
    logic [63:0] flat;
    flat = h;
    fsc_hdr_byte = flat[8'(63 - 8 * int'(pos)) -: 8];
  endfunction : fsc_hdr_byte
endpackage : fsc_pkg

// File: logic/fsc_link_if.sv
`timescale 1ns/1ps
// Byte streams between requester and storage handler, plus frame addressing
interface fsc_link_if;
  // Request stream, requester to handler
  logic        req_valid;
  logic        req_ready;
  logic [7:0]  req_data;
  logic        req_last;
  logic        req_bcast;
  logic [15:0] req_cluster;
  logic [7:0]  req_dst_ep;
  logic [7:0]  req_src_ep;
  // Response stream, handler to requester
  logic        rsp_valid;
  logic        rsp_ready;
  logic [7:0]  rsp_data;
  logic        rsp_last;
  logic [7:0]  rsp_dst_ep;

  modport handler (
    input  req_valid, req_data, req_last, req_bcast, req_cluster, req_dst_ep, req_src_ep,
    output req_ready,
    output rsp_valid, rsp_data, rsp_last, rsp_dst_ep,
    input  rsp_ready
  );
  modport requester (
    output req_valid, req_data, req_last, req_bcast, req_cluster, req_dst_ep, req_src_ep,
    input  req_ready,
    input  rsp_valid, rsp_data, rsp_last, rsp_dst_ep,
    output rsp_ready
  );
endinterface : fsc_link_if

// File: logic/fsc_handler.sv
`timescale 1ns/1ps
// What this block does
// - Offers 119 storage blocks of 512 bytes
// - Requests target cluster 0x23, endpoint 0xE6
// - Header: code, options, block, offset, count
// - Multi-byte header fields sent big-endian
// - Unicast request answered to source endpoint
// - Broadcast requests never get a response
// - Requester marks reply explicit only when source endpoint is 0xE6
// - Reply: request code with bit 7 set, status, same layout
// - Geometry query: code 0x00, fields zero
// - Geometry reply carries code 0x80
// - Status bit 0 flags error
// - Block field holds total block count
// - Offset field holds block size
// - Count field zero, no data bytes
module fsc_handler
  import fsc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  // Link to requester
  fsc_link_if.handler link,
  // Status toward the radio core
  output logic      busy,
  output logic      unknown_cmd_seen
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Gray order along the usual path: RECV, BUILD, SEND, DROP
  typedef enum logic [1:0] {
    FSC_S_RECV = 2'b00,
    FSC_S_BUILD = 2'b01,
    FSC_S_SEND = 2'b11,
    FSC_S_DROP = 2'b10
  } fsc_hstate_t;

  // All state in one word; one process fills the copy, one registers it
  typedef struct packed {
    fsc_hstate_t st;
    logic [3:0]  pos;
    logic        bad;
    logic        mine;
    fsc_hdr_t    hdr;
    logic [7:0]  src_ep;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        rsp_last;
    logic [7:0]  rsp_dst;
    logic        unk;
    logic        rdy;       // Registered request ready
    logic        busy;      // Registered busy flag
  } fsc_hreg_t;

  fsc_hreg_t cur_ff;
  fsc_hreg_t nxt_cur;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Write one received header byte into its field
  function automatic fsc_hdr_t put_byte(input fsc_hdr_t h, input logic [3:0] pos,
                                        input logic [7:0] b);
    logic [63:0] flat;
    flat = h;
    flat[8'(63 - 8 * int'(pos)) -: 8] = b;
    put_byte = flat;
  endfunction : put_byte

  // Frame aimed at this service; a broadcast never qualifies
  function automatic logic frame_for_us(input logic        bcast,
                                        input logic [15:0] cluster,
                                        input logic [7:0]  dst_ep);
    frame_for_us = !bcast &&
                   (cluster == FSC_CLUSTER) &&
                   (dst_ep == FSC_ENDPOINT);
  endfunction : frame_for_us

  // Full geometry query; a short header falls back to an error reply
  function automatic logic geom_ok(input fsc_hdr_t h,
                                   input logic     short_hdr);
    geom_ok = (h.code == FSC_CMD_GEOM_QUERY) && !short_hdr;
  endfunction : geom_ok

  // Receive-state test, shared by the ready and busy flags
  function automatic logic state_is_recv(input fsc_hstate_t s);
    state_is_recv = (s == FSC_S_RECV);
  endfunction : state_is_recv

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Reply timing: the edge that takes the last request byte enters BUILD,
  // the next edge enters SEND, and the edge after that loads byte 0.
  // Bytes past the eighth are dropped; the header alone shapes the reply.
  // A frame not aimed here still spends one cycle in BUILD before RECV.
  // DROP adds one idle cycle after the last reply byte is taken, so a
  // request queued behind the reply cannot start a second one early.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.unk = 1'b0;
    case (cur_ff.st)
      FSC_S_RECV: begin
        if (link.req_valid) begin
          // First byte latches addressing and frame kind
          if (cur_ff.pos == FSC_POS_ZERO) begin
            nxt_cur.src_ep = link.req_src_ep;
            nxt_cur.mine   = frame_for_us(link.req_bcast,
                                          link.req_cluster,
                                          link.req_dst_ep);
            nxt_cur.bad    = 1'b0;
          end
          if (cur_ff.pos <= FSC_POS_LAST) begin
            nxt_cur.hdr = put_byte(cur_ff.hdr, cur_ff.pos, link.req_data);
            nxt_cur.pos = cur_ff.pos + FSC_POS_ONE;
          end
          if (link.req_last) begin
            // Short header is refused with an error status
            if (cur_ff.pos < FSC_POS_LAST) begin
              nxt_cur.bad = 1'b1;
            end
            nxt_cur.pos = FSC_POS_ZERO;
            nxt_cur.st  = FSC_S_BUILD;
          end
        end
      end
      FSC_S_BUILD: begin
        if (!cur_ff.mine) begin
          nxt_cur.st = FSC_S_RECV;
        end else begin
          if (geom_ok(cur_ff.hdr, cur_ff.bad)) begin
            nxt_cur.hdr.code = FSC_CMD_GEOM_REPLY;
            nxt_cur.hdr.opts = FSC_STATUS_OK;
            nxt_cur.hdr.blk  = FSC_BLOCK_TOTAL;
            nxt_cur.hdr.ofs  = FSC_BLOCK_BYTES;
          end else begin
            // Other commands live elsewhere; report an error, keep block and offset fields
            nxt_cur.hdr.code = cur_ff.hdr.code | FSC_REPLY_FLAG;
            nxt_cur.hdr.opts = FSC_STATUS_ERR;
            nxt_cur.unk      = 1'b1;
          end
          // Neither reply kind carries data bytes
          nxt_cur.hdr.cnt   = 16'h0000;
          nxt_cur.rsp_dst   = cur_ff.src_ep;
          nxt_cur.st        = FSC_S_SEND;
          nxt_cur.pos       = FSC_POS_ZERO;
        end
      end
      FSC_S_SEND: begin
        // Load a byte whenever the output register is free, or being taken and not holding the last byte
        // A stalled byte simply stands until taken, so none is lost
        if (!cur_ff.rsp_valid || link.rsp_ready) begin
          if (cur_ff.rsp_valid && cur_ff.rsp_last) begin
            nxt_cur.rsp_valid = 1'b0;
            nxt_cur.rsp_last  = 1'b0;
            nxt_cur.st        = FSC_S_DROP;
          end else begin
            nxt_cur.rsp_valid = 1'b1;
            nxt_cur.rsp_data  = fsc_hdr_byte(cur_ff.hdr, cur_ff.pos);
            nxt_cur.rsp_last  = (cur_ff.pos == FSC_POS_LAST);
            nxt_cur.pos       = cur_ff.pos + FSC_POS_ONE;
          end
        end
      end
      FSC_S_DROP: begin
        // One idle cycle so exactly one reply goes out per request
        nxt_cur.pos = FSC_POS_ZERO;
        nxt_cur.st  = FSC_S_RECV;
      end
      default: begin
        nxt_cur.st = FSC_S_RECV;
      end
    endcase
    // Ready and busy follow the next state, one register deep
    nxt_cur.rdy  = state_is_recv(nxt_cur.st);
    nxt_cur.busy = !state_is_recv(nxt_cur.st);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Enable low freezes every field, the outputs with them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_ff     <= '0;
      // Idle state accepts at once, so ready leaves reset high
      cur_ff.rdy <= 1'b1;
    end else if (clk_en) begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All straight from the state register. Ready ignores the enable: both
  // ends share it, so an edge with the enable low moves neither side.
  assign link.req_ready   = cur_ff.rdy;
  assign link.rsp_valid   = cur_ff.rsp_valid;
  assign link.rsp_data    = cur_ff.rsp_data;
  assign link.rsp_last    = cur_ff.rsp_last;
  assign link.rsp_dst_ep  = cur_ff.rsp_dst;
  assign busy             = cur_ff.busy;
  assign unknown_cmd_seen = cur_ff.unk;

endmodule : fsc_handler

// File: logic/fsc_requester.sv
`timescale 1ns/1ps
// Requester end: sends geometry queries, buffers reply bytes for the user
module fsc_requester
  import fsc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // Link to handler
  fsc_link_if.requester   link,
  // User command side
  input  wire logic       query_start,
  input  wire logic       query_bcast,
  input  wire logic [7:0] query_src_ep,
  output logic            query_busy,
  // User reply stream
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  output logic            rx_explicit,
  input  wire logic       rx_ready
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [0:0] {
    FSC_R_IDLE = 1'b0,
    FSC_R_SEND = 1'b1
  } fsc_rstate_t;

  typedef struct packed {
    fsc_rstate_t st;
    logic [3:0]  pos;
    logic        bcast;
    logic [7:0]  src_ep;
    logic        explicit;
    logic [1:0]  cnt;
    logic [1:0][8:0] buf_q;
    logic        rx_valid;
    logic [8:0]  rx_word;
  } fsc_rreg_t;

  fsc_rreg_t cur_ff;
  fsc_rreg_t nxt_cur;
  fsc_hdr_t  query_hdr;
  logic      push;
  logic      pull;

  // Geometry query: all fields zero, no data
  assign query_hdr = '{code: FSC_CMD_GEOM_QUERY, opts: 8'h00, blk: 16'h0000,
                       ofs: 16'h0000, cnt: 16'h0000};

  // Two-entry buffer: stall on the link when both slots are taken or the enable is low
  assign push = link.rsp_valid && (cur_ff.cnt != 2'h2);
  assign pull = (cur_ff.cnt != 2'h0) && (!cur_ff.rx_valid || rx_ready);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    case (cur_ff.st)
      FSC_R_IDLE: begin
        if (query_start) begin
          nxt_cur.st     = FSC_R_SEND;
          nxt_cur.pos    = FSC_POS_ZERO;
          nxt_cur.bcast  = query_bcast;
          nxt_cur.src_ep = query_src_ep;
          // Explicit output when reply comes back to the storage endpoint
          nxt_cur.explicit = (query_src_ep == FSC_ENDPOINT);
        end
      end
      FSC_R_SEND: begin
        if (link.req_ready) begin
          nxt_cur.pos = cur_ff.pos + FSC_POS_ONE;
          if (cur_ff.pos == FSC_POS_LAST) begin
            nxt_cur.st = FSC_R_IDLE;
          end
        end
      end
      default: begin
        nxt_cur.st = FSC_R_IDLE;
      end
    endcase
    // Output stage drains, then buffer shifts down
    if (cur_ff.rx_valid && rx_ready) begin
      nxt_cur.rx_valid = 1'b0;
    end
    if (pull) begin
      nxt_cur.rx_valid = 1'b1;
      nxt_cur.rx_word  = cur_ff.buf_q[0];
      nxt_cur.buf_q[0] = cur_ff.buf_q[1];
    end
    if (push) begin
      nxt_cur.buf_q[2'(cur_ff.cnt - (pull ? 2'h1 : 2'h0))] = {link.rsp_last, link.rsp_data};
    end
    nxt_cur.cnt = 2'(cur_ff.cnt + (push ? 2'h1 : 2'h0) - (pull ? 2'h1 : 2'h0));
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_ff <= '0;
    end else if (clk_en) begin
      cur_ff <= nxt_cur;
    end
  end

  // Request stream driven from registered position
  assign link.req_valid   = (cur_ff.st == FSC_R_SEND);
  assign link.req_data    = fsc_hdr_byte(query_hdr, cur_ff.pos);
  assign link.req_last    = (cur_ff.st == FSC_R_SEND) && (cur_ff.pos == FSC_POS_LAST);
  assign link.req_bcast   = cur_ff.bcast;
  assign link.req_cluster = FSC_CLUSTER;
  assign link.req_dst_ep  = FSC_ENDPOINT;
  assign link.req_src_ep  = cur_ff.src_ep;
  assign link.rsp_ready   = (cur_ff.cnt != 2'h2) && clk_en;
  assign query_busy       = (cur_ff.st != FSC_R_IDLE);
  assign rx_valid         = cur_ff.rx_valid;
  assign rx_data          = cur_ff.rx_word[7:0];
  assign rx_last          = cur_ff.rx_word[8];
  assign rx_explicit      = cur_ff.explicit;

endmodule : fsc_requester

// File: dv/fsc_link_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link checker for the handler facing the requester
// ----------------------------------------
module fsc_link_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Request stream
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_data,
  input wire logic        req_last,
  input wire logic        req_bcast,
  input wire logic [15:0] req_cluster,
  input wire logic [7:0]  req_dst_ep,
  input wire logic [7:0]  req_src_ep,
  // Response stream
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_last,
  input wire logic [7:0]  rsp_dst_ep
);
  logic [3:0] idx_ff;
  logic [7:0] src_ff;
  logic       req_end;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Reply byte position and requester endpoint, so each field is judged by place
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_ff <= 4'h0;
      src_ff <= 8'h00;
    end else begin
      if (rsp_valid && rsp_ready) idx_ff <= rsp_last ? 4'h0 : idx_ff + 4'h1;
      if (req_valid && req_ready) src_ff <= req_src_ep;
    end
  end
  assign req_end = req_valid && req_ready && req_last;

  a_reply_timing: assert property (req_end && !req_bcast && req_cluster == 16'h0023
    && req_dst_ep == 8'hE6 |=> !rsp_valid [*2] ##1 (rsp_valid && idx_ff == 4'h0))
    else $error("reply did not start three cycles after request end");
  a_bcast_silent: assert property (req_end && req_bcast |=> !rsp_valid [*8])
    else $error("reply sent for a broadcast request");
  a_reply_stall: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data) && $stable(rsp_last))
    else $error("reply byte changed while stalled");
  a_reply_dest: assert property (rsp_valid |-> rsp_dst_ep == src_ff)
    else $error("reply endpoint differs from request source");
  a_reply_code: assert property (rsp_valid && idx_ff == 4'h0 |-> rsp_data == 8'h80)
    else $error("wrong geometry reply code");
  a_status_clear: assert property (rsp_valid && idx_ff == 4'h1 |-> rsp_data == 8'h00)
    else $error("error status on a good geometry query");
  a_block_total: assert property (rsp_valid && idx_ff inside {4'h2, 4'h3} |->
    rsp_data == (idx_ff == 4'h2 ? 8'h00 : 8'h77))
    else $error("block total field wrong");
  a_block_size: assert property (rsp_valid && idx_ff inside {4'h4, 4'h5} |->
    rsp_data == (idx_ff == 4'h4 ? 8'h02 : 8'h00))
    else $error("block size field wrong");
  a_count_zero: assert property (rsp_valid && idx_ff >= 4'h6 |->
    rsp_data == 8'h00 && rsp_last == (idx_ff == 4'h7))
    else $error("count field not zero or reply length wrong");
  a_reply_gap: assert property (rsp_valid && rsp_ready && rsp_last |=>
    !rsp_valid && !req_ready)
    else $error("no idle cycle after reply");
endmodule : fsc_link_props

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys, rst, clk_en, query_start, query_bcast, rx_ready, stall;
  logic        query_busy, rx_valid, rx_last, rx_explicit, busy, unk, busy_b, unk_b;
  logic [7:0]  query_src_ep, rx_data;
  logic [31:0] f;
  logic [9:0]  rx_q[$];
  logic [16:0] b_q[$];
  integer      seed = 69;
  int          fails = 0, compares = 0, cyc = 0, unk_cnt = 0, k;
  localparam logic [63:0] GEOM = 64'h8000_0077_0200_0000;

  // ----------------------------------------
  // Both ends face each other; a second handler is driven directly
  // ----------------------------------------
  fsc_link_if link();
  fsc_link_if link_b();
  fsc_handler i_fsc_handler (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .link(link),
    .busy(busy), .unknown_cmd_seen(unk));
  fsc_handler i_fsc_handler_b (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .link(link_b),
    .busy(busy_b), .unknown_cmd_seen(unk_b));
  fsc_requester i_fsc_requester (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .link(link),
    .query_start(query_start), .query_bcast(query_bcast), .query_src_ep(query_src_ep),
    .query_busy(query_busy), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_explicit(rx_explicit), .rx_ready(rx_ready));
  fsc_link_props i_fsc_link_props (.clk_sys(clk_sys), .rst(rst), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_data(link.req_data), .req_last(link.req_last),
    .req_bcast(link.req_bcast), .req_cluster(link.req_cluster), .req_dst_ep(link.req_dst_ep),
    .req_src_ep(link.req_src_ep), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_data(link.rsp_data), .rsp_last(link.rsp_last), .rsp_dst_ep(link.rsp_dst_ep));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // Random receiver stalls on both reply paths
  always @(negedge clk_sys) begin
    rx_ready <= !stall && ($random(seed) % 4 != 0);
    link_b.rsp_ready <= ($random(seed) % 3 != 0);
  end

  // Watcher: each reply byte takes the oldest note; a byte with no note is a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
    unk_cnt += int'(unk === 1'b1) + int'(unk_b === 1'b1);
    if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1)
      check(17'({rx_explicit, rx_last, rx_data}),
            17'(rx_q.size() ? rx_q.pop_front() : 10'h3FF));
    if (!rst && link_b.rsp_valid === 1'b1 && link_b.rsp_ready === 1'b1)
      check({link_b.rsp_last, link_b.rsp_dst_ep, link_b.rsp_data},
            b_q.size() ? b_q.pop_front() : 17'h1FFFF);
  end

  // Geometry query through the requester, optionally stalling its user side
  task automatic query(input logic bc, input logic [7:0] ep, input int st);
    int i;
    @(negedge clk_sys);
    query_bcast = bc;
    query_src_ep = ep;
    query_start = 1'b1;
    for (i = 0; i < 8 && !bc; i++) rx_q.push_back({ep == 8'hE6, i == 7, GEOM[63-8*i -: 8]});
    stall = (st > 0);
    @(negedge clk_sys);
    query_start = 1'b0;
    check(17'(query_busy), 17'h1);
    repeat (st) @(negedge clk_sys);
    if (st > 0) check(17'(link.rsp_ready), 17'h0);
    stall = 1'b0;
    i = 0;
    while ((query_busy !== 1'b0 || rx_q.size() > 0) && i < 200) begin
      @(negedge clk_sys);
      i++;
    end
    check(17'(rx_q.size()), 17'h0);
    repeat (12) @(negedge clk_sys);
    check(17'(busy), 17'h0);
  endtask : query

  // Raw frame into the second handler; exp is the reply header when one is due
  task automatic send_b(input logic [63:0] hdr, input logic [15:0] cl, input logic [7:0] ep,
                        input logic [63:0] exp, input logic reply);
    int i;
    int t;
    for (i = 0; i < 8 && reply; i++) b_q.push_back({i == 7, 8'h41, exp[63-8*i -: 8]});
    link_b.req_cluster = cl;
    link_b.req_dst_ep = ep;
    link_b.req_src_ep = 8'h41;
    for (i = 0; i < 8; i++) begin
      link_b.req_valid = 1'b1;
      link_b.req_data = hdr[63-8*i -: 8];
      link_b.req_last = (i == 7);
      t = 0;
      while (link_b.req_ready !== 1'b1 && t < 100) begin
        @(negedge clk_sys);
        t++;
      end
      @(negedge clk_sys);
    end
    check(17'(busy_b), 17'h1);
    link_b.req_valid = 1'b0;
    link_b.req_last = 1'b0;
    link_b.req_data = ~link_b.req_data;
    t = 0;
    while (b_q.size() > 0 && t < 100) begin
      @(negedge clk_sys);
      t++;
    end
    check(17'(b_q.size()), 17'h0);
    repeat (24) @(negedge clk_sys);
    check(17'(busy_b), 17'h0);
  endtask : send_b

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    stall = 1'b0;
    query_start = 1'b0;
    query_bcast = 1'b0;
    query_src_ep = 8'h00;
    link_b.req_valid = 1'b0;
    link_b.req_last = 1'b0;
    link_b.req_data = 8'h00;
    link_b.req_bcast = 1'b0;
    link_b.req_cluster = 16'h0000;
    link_b.req_dst_ep = 8'h00;
    link_b.req_src_ep = 8'h00;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    query(1'b0, 8'hE6, 25);
    query(1'b0, 8'h11, 0);
    query(1'b1, 8'hE6, 0);
    for (k = 0; k < 3; k++) query(1'b0, 8'($random(seed)), 0);
    send_b(64'h0, 16'h0024, 8'hE6, 64'h0, 1'b0);
    send_b(64'h0, 16'h0023, 8'hE7, 64'h0, 1'b0);
    send_b(64'h0, 16'h0023, 8'hE6, GEOM, 1'b1);
    for (k = 1; k < 4; k++) begin
      f = $random(seed);
      send_b({8'(k), 8'h00, f, 16'h0004}, 16'h0023, 8'hE6,
             {8'(k) | 8'h80, 8'h01, f, 16'h0000}, 1'b1);
    end
    check(17'(unk_cnt), 17'h3);
    give_verdict();
  end
endmodule : tb_top
